// ### srpcs_params.svh
// Constants for the receiver status and control block
`ifndef SRPCS_PARAMS_SVH
`define SRPCS_PARAMS_SVH
`define SRPCS_BYTE_W 8
`define SRPCS_BYTES_PER_CH 2
`define SRPCS_NUM_CH 1
`define SRPCS_FLAG_MIN_NOSER 2
`define SRPCS_FLAG_MIN_SER 3
`define SRPCS_PCFIFO_DEPTH 8
`define SRPCS_ERR_NONE 2'b00
`define SRPCS_ERR_CODE 2'b10
`define SRPCS_ERR_DISP 2'b11
`endif

// ### srpcs_pkg.sv
// Types for the receiver status and control block
package srpcs_pkg;
	typedef enum logic [1:0]
	{
		SRPCS_CDR_AUTO = 2'b00,
		SRPCS_CDR_REF = 2'b01,
		SRPCS_CDR_DATA = 2'b10
	} srpcs_lock_mode_t;
	typedef enum logic [1:0]
	{
		SRPCS_ORD_IDLE = 2'b00,
		SRPCS_ORD_SEARCH = 2'b01,
		SRPCS_ORD_FOUND = 2'b10
	} srpcs_ord_state_t;
endpackage

// ### srpcs_sync.sv
// Two-stage synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module srpcs_sync #(
	parameter int WIDTH = 1
)
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end
	assign o_sync = sync_reg;
endmodule

// ### srpcs_mem.sv
// Phase-compensation FIFO storage with registered read data
`timescale 1ns/1ps
module srpcs_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)
(
	input wire logic i_ref_clk,
	input wire logic i_wr_en,
	input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_reg;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
		rd_reg <= mem[i_rd_addr];
	end
	assign o_rd_data = rd_reg;
endmodule

// ### srpcs_top.sv
// Receiver PCS status and control channel logic
// Notes on behaviour
// R1 - Full flag high when rate-match FIFO full
// R2 - Empty flag high when rate-match FIFO empty
// R3 - Full/empty pulses last two or three cycles
// R4 - Control indicator: one bit per byte
// R5 - Error pair 00 none, 10 code, 11 disparity
// R6 - Disparity error bit per byte on violation
// R7 - Running disparity bit high when negative
// R8 - Restart byte ordering on restart rising edge
// R9 - Status high when pattern in low byte
// R10 - Data bus width is channel times channels
// R11 - Recovered clock only without rate-match FIFO
// R12 - Fabric read clock has zero frequency offset
// R13 - Phase FIFO error when full or empty
// R14 - Reference lock indicator follows loop lock
// R15 - Lock mode high when tracking data
// R16 - Mode inputs: 00 auto, 01 ref, 1x data
// R17 - Signal detect high above threshold in PCIe mode, or in basic mode with decoding
// R18 - PCIe without inference: idle is inverted detect
// R19 - Loopback select: 0 normal, 1 serial loopback
// R20 - Outputs synchronous to the core clock
// R21 - Shared clock reads bonded phase FIFOs
// R22 - Asynchronous controls pass two-stage synchroniser
// R23 - Indicators held low without decoding
`timescale 1ns/1ps
`include "srpcs_params.svh"
module srpcs_top
	import srpcs_pkg::*;
#(
	parameter int BYTE_W = `SRPCS_BYTE_W,
	parameter int BYTES_PER_CH = `SRPCS_BYTES_PER_CH,
	parameter int NUM_CH = `SRPCS_NUM_CH,
	parameter int PC_DEPTH = `SRPCS_PCFIFO_DEPTH,
	parameter logic [BYTE_W-1:0] ORDER_PATTERN = 8'hbc
)
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_byte_ser_present,
	input wire logic i_rm_fifo_used,
	input wire logic i_dec_enable,
	input wire logic i_order_enable,
	input wire logic i_pcie_mode,
	input wire logic i_basic_mode,
	input wire logic i_idle_infer_en,
	input wire logic i_rm_full_raw,
	input wire logic i_rm_empty_raw,
	input wire logic i_rx_valid,
	input wire logic [BYTES_PER_CH*NUM_CH*BYTE_W-1:0] i_rx_byte,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_is_ctrl,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_code_err,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_disp_viol,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_rd_neg,
	input wire logic i_rd_ready,
	input wire logic i_order_restart,
	input wire logic i_lock_to_data,
	input wire logic i_lock_to_ref,
	input wire logic i_loop_locked_ref,
	input wire logic i_loop_on_data,
	input wire logic i_loopback_sel,
	input wire logic i_amp_above_thr,
	output logic o_rm_full,
	output logic o_rm_empty,
	output logic [BYTES_PER_CH*NUM_CH-1:0] o_ctrl_detect,
	output logic [BYTES_PER_CH*NUM_CH-1:0] o_err_detect,
	output logic [BYTES_PER_CH*NUM_CH-1:0] o_disp_err,
	output logic [BYTES_PER_CH*NUM_CH-1:0] o_running_disp,
	output logic o_order_status,
	output logic [BYTES_PER_CH*NUM_CH*BYTE_W-1:0] o_rx_data,
	output logic o_rx_data_valid,
	output logic o_rec_clk_en,
	output logic o_pc_fifo_error,
	output logic o_loop_ref_locked,
	output logic o_loop_data_mode,
	output logic [1:0] o_loop_mode_sel,
	output logic o_signal_detect,
	output logic o_pipe_elec_idle,
	output logic o_serial_loopback
);
	localparam int NB = BYTES_PER_CH * NUM_CH;
	localparam int DW = NB * BYTE_W; // R10
	localparam int AW = $clog2(PC_DEPTH);
	localparam int NSYNC = 6;

	// Refuse widths and depths the pointer logic cannot serve
	if (BYTE_W < 1 || NB < 1 || PC_DEPTH < 2
		|| (PC_DEPTH & (PC_DEPTH - 1)) != 0)
	begin : g_bad_params
		$error("srpcs_top: unsupported parameter values");
	end

	// Asynchronous controls
	logic [NSYNC-1:0] sync_in;
	logic [NSYNC-1:0] sync_out;
	assign sync_in = {i_order_restart, i_lock_to_data, i_lock_to_ref,
		i_loopback_sel, i_loop_locked_ref, i_loop_on_data};
	srpcs_sync #(.WIDTH(NSYNC)) u_sync ( // R22
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_async(sync_in),
		.o_sync(sync_out)
	);
	logic restart_s;
	logic l2d_s;
	logic l2r_s;
	logic lpbk_s;
	logic locked_s;
	logic ondata_s;
	assign {restart_s, l2d_s, l2r_s, lpbk_s, locked_s, ondata_s} = sync_out;

	// Rate-match flag stretching
	logic rm_full_reg;
	logic rm_full_next;
	logic rm_empty_reg;
	logic rm_empty_next;
	logic [1:0] full_cnt_reg;
	logic [1:0] full_cnt_next;
	logic [1:0] empty_cnt_reg;
	logic [1:0] empty_cnt_next;
	logic [1:0] hold_min;

	always_comb
	begin
		hold_min = i_byte_ser_present ? 2'(`SRPCS_FLAG_MIN_SER)
			: 2'(`SRPCS_FLAG_MIN_NOSER); // R3
		full_cnt_next = full_cnt_reg;
		empty_cnt_next = empty_cnt_reg;
		rm_full_next = rm_full_reg;
		rm_empty_next = rm_empty_reg;
		if (i_rm_full_raw) // R1
		begin
			rm_full_next = 1'b1;
			full_cnt_next = (rm_full_reg) ? full_cnt_reg : 2'h1;
			if (rm_full_reg && full_cnt_reg < hold_min)
				full_cnt_next = full_cnt_reg + 2'h1;
		end
		else if (rm_full_reg && full_cnt_reg < hold_min) // R3
			full_cnt_next = full_cnt_reg + 2'h1;
		else
		begin
			rm_full_next = 1'b0;
			full_cnt_next = 2'h0;
		end
		if (i_rm_empty_raw) // R2
		begin
			rm_empty_next = 1'b1;
			empty_cnt_next = (rm_empty_reg) ? empty_cnt_reg : 2'h1;
			if (rm_empty_reg && empty_cnt_reg < hold_min)
				empty_cnt_next = empty_cnt_reg + 2'h1;
		end
		else if (rm_empty_reg && empty_cnt_reg < hold_min) // R3
			empty_cnt_next = empty_cnt_reg + 2'h1;
		else
		begin
			rm_empty_next = 1'b0;
			empty_cnt_next = 2'h0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rm_full_reg <= 1'b0;
			rm_empty_reg <= 1'b0;
			full_cnt_reg <= 2'h0;
			empty_cnt_reg <= 2'h0;
		end
		else
		begin
			rm_full_reg <= rm_full_next;
			rm_empty_reg <= rm_empty_next;
			full_cnt_reg <= full_cnt_next;
			empty_cnt_reg <= empty_cnt_next;
		end
	end
	assign o_rm_full = rm_full_reg;
	assign o_rm_empty = rm_empty_reg;

	// Decoder indicators per byte
	logic [NB-1:0] ctrl_reg;
	logic [NB-1:0] ctrl_next;
	logic [NB-1:0] err_reg;
	logic [NB-1:0] err_next;
	logic [NB-1:0] disp_reg;
	logic [NB-1:0] disp_next;
	logic [NB-1:0] rdneg_reg;
	logic [NB-1:0] rdneg_next;

	genvar gb;
	generate
		for (gb = 0; gb < NB; gb++)
		begin : g_byte
			always_comb
			begin
				ctrl_next[gb] = 1'b0;
				err_next[gb] = 1'b0;
				disp_next[gb] = 1'b0;
				rdneg_next[gb] = 1'b0;
				if (i_dec_enable && i_rx_valid) // R23
				begin
					ctrl_next[gb] = i_rx_is_ctrl[gb]; // R4
					// Disparity error wins over code error in the pair
					if (i_rx_disp_viol[gb]) // R5
					begin
						{err_next[gb], disp_next[gb]} = `SRPCS_ERR_DISP; // R6
					end
					else if (i_rx_code_err[gb])
					begin
						{err_next[gb], disp_next[gb]} = `SRPCS_ERR_CODE; // R5
					end
					else
					begin
						{err_next[gb], disp_next[gb]} = `SRPCS_ERR_NONE;
					end
					rdneg_next[gb] = i_rx_rd_neg[gb]; // R7
				end
				else if (i_dec_enable)
				begin
					ctrl_next[gb] = ctrl_reg[gb];
					err_next[gb] = err_reg[gb];
					disp_next[gb] = disp_reg[gb];
					rdneg_next[gb] = rdneg_reg[gb];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk or negedge i_reset_n) // R20
	begin
		if (!i_reset_n)
		begin
			ctrl_reg <= '0;
			err_reg <= '0;
			disp_reg <= '0;
			rdneg_reg <= '0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			err_reg <= err_next;
			disp_reg <= disp_next;
			rdneg_reg <= rdneg_next;
		end
	end
	assign o_ctrl_detect = ctrl_reg;
	assign o_err_detect = err_reg;
	assign o_disp_err = disp_reg;
	assign o_running_disp = rdneg_reg;

	// Byte ordering search
	srpcs_ord_state_t ord_reg;
	srpcs_ord_state_t ord_next;
	logic restart_d_reg;
	logic status_reg;
	logic restart_rise;
	assign restart_rise = restart_s && !restart_d_reg;

	always_comb
	begin
		ord_next = ord_reg;
		if (!i_order_enable)
			ord_next = SRPCS_ORD_IDLE;
		else if (restart_rise) // R8
			ord_next = SRPCS_ORD_SEARCH;
		else
		begin
			unique case (ord_reg)
				SRPCS_ORD_IDLE:
					ord_next = SRPCS_ORD_SEARCH;
				SRPCS_ORD_SEARCH:
					if (i_rx_valid && i_rx_byte[BYTE_W-1:0] == ORDER_PATTERN)
						ord_next = SRPCS_ORD_FOUND; // R9
				SRPCS_ORD_FOUND:
					ord_next = SRPCS_ORD_FOUND;
				default:
					ord_next = SRPCS_ORD_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ord_reg <= SRPCS_ORD_IDLE;
			restart_d_reg <= 1'b0;
			status_reg <= 1'b0;
		end
		else
		begin
			ord_reg <= ord_next;
			restart_d_reg <= restart_s;
			status_reg <= (ord_next == SRPCS_ORD_FOUND);
		end
	end
	assign o_order_status = status_reg; // R9

	// Receive phase-compensation FIFO
	logic [AW:0] wptr_reg;
	logic [AW:0] wptr_next;
	logic [AW:0] rptr_reg;
	logic [AW:0] rptr_next;
	logic pc_full;
	logic pc_empty;
	logic wr_en;
	logic rd_en;
	logic rvalid_reg;
	logic rvalid_next;
	logic pcerr_reg;
	logic pcerr_next;
	logic [DW-1:0] mem_rd;

	always_comb
	begin
		pc_full = (wptr_reg[AW] != rptr_reg[AW])
			&& (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
		pc_empty = (wptr_reg == rptr_reg);
		wr_en = i_rx_valid && !pc_full;
		rd_en = i_rd_ready && !pc_empty; // R21
		wptr_next = wr_en ? wptr_reg + (AW+1)'(1) : wptr_reg;
		rptr_next = rd_en ? rptr_reg + (AW+1)'(1) : rptr_reg;
		rvalid_next = rd_en;
		pcerr_next = pc_full || pc_empty; // R13
	end

	srpcs_mem #(.WIDTH(DW), .DEPTH(PC_DEPTH)) u_mem (
		.i_ref_clk(i_ref_clk),
		.i_wr_en(wr_en),
		.i_wr_addr(wptr_reg[AW-1:0]),
		.i_wr_data(i_rx_byte),
		.i_rd_addr(rptr_reg[AW-1:0]),
		.o_rd_data(mem_rd)
	);

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			rvalid_reg <= 1'b0;
			pcerr_reg <= 1'b1;
		end
		else
		begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			rvalid_reg <= rvalid_next;
			pcerr_reg <= pcerr_next;
		end
	end
	assign o_rx_data = mem_rd; // R10
	assign o_rx_data_valid = rvalid_reg;
	assign o_pc_fifo_error = pcerr_reg;

	// Clock recovery, detect and loopback status
	logic rec_clk_reg;
	logic ref_lock_reg;
	logic data_mode_reg;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic sigdet_reg;
	logic sigdet_next;
	logic idle_reg;
	logic idle_next;
	logic lpbk_reg;

	always_comb
	begin
		if (l2d_s) // R16
			mode_next = SRPCS_CDR_DATA;
		else if (l2r_s)
			mode_next = SRPCS_CDR_REF;
		else
			mode_next = SRPCS_CDR_AUTO;
		sigdet_next = (i_pcie_mode || (i_basic_mode && i_dec_enable))
			&& i_amp_above_thr; // R17
		idle_next = (i_pcie_mode && !i_idle_infer_en) ? !i_amp_above_thr
			: 1'b0; // R18
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rec_clk_reg <= 1'b0;
			ref_lock_reg <= 1'b0;
			data_mode_reg <= 1'b0;
			mode_reg <= SRPCS_CDR_AUTO;
			sigdet_reg <= 1'b0;
			idle_reg <= 1'b0;
			lpbk_reg <= 1'b0;
		end
		else
		begin
			rec_clk_reg <= !i_rm_fifo_used; // R11
			ref_lock_reg <= locked_s; // R14
			data_mode_reg <= ondata_s; // R15
			mode_reg <= mode_next;
			sigdet_reg <= sigdet_next;
			idle_reg <= idle_next;
			lpbk_reg <= lpbk_s; // R19
		end
	end
	assign o_rec_clk_en = rec_clk_reg;
	assign o_loop_ref_locked = ref_lock_reg;
	assign o_loop_data_mode = data_mode_reg;
	assign o_loop_mode_sel = mode_reg;
	assign o_signal_detect = sigdet_reg;
	assign o_pipe_elec_idle = idle_reg;
	assign o_serial_loopback = lpbk_reg;
endmodule

// ### srpcs_top_props.sv
// Concurrent checks on the receiver status and control ports
`timescale 1ns/1ps
module srpcs_top_props #(
	parameter int BYTE_W = 8,
	parameter int BYTES_PER_CH = 2,
	parameter int NUM_CH = 1,
	parameter logic [BYTE_W-1:0] ORDER_PATTERN = 8'hbc
)
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_dec_enable,
	input wire logic i_byte_ser_present,
	input wire logic i_rm_full_raw,
	input wire logic i_rm_empty_raw,
	input wire logic i_rx_valid,
	input wire logic [BYTES_PER_CH*NUM_CH*BYTE_W-1:0] i_rx_byte,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_is_ctrl,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_code_err,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_disp_viol,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] i_rx_rd_neg,
	input wire logic i_lock_to_data,
	input wire logic i_lock_to_ref,
	input wire logic o_rm_full,
	input wire logic o_rm_empty,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] o_ctrl_detect,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] o_err_detect,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] o_disp_err,
	input wire logic [BYTES_PER_CH*NUM_CH-1:0] o_running_disp,
	input wire logic o_order_status,
	input wire logic [1:0] o_loop_mode_sel
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	logic dv;
	assign dv = i_rx_valid && i_dec_enable;
	property p_full;
		i_rm_full_raw |=> o_rm_full;
	endproperty
	a_full: assert property (p_full) else $error("full flag missed");
	property p_empty;
		i_rm_empty_raw |=> o_rm_empty;
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag missed");
	property p_hold;
		$rose(o_rm_full) |-> o_rm_full[*2];
	endproperty
	a_hold: assert property (p_hold) else $error("full flag too short");
	property p_hold_ser;
		$rose(o_rm_full) && i_byte_ser_present |-> o_rm_full[*3];
	endproperty
	a_hold_ser: assert property (p_hold_ser) else $error("full hold short");
	property p_hold_e;
		$rose(o_rm_empty) |-> o_rm_empty[*2];
	endproperty
	a_hold_e: assert property (p_hold_e) else $error("empty hold short");
	property p_ctrl;
		dv |=> o_ctrl_detect == $past(i_rx_is_ctrl);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control bits wrong");
	property p_pair;
		dv |=> o_err_detect == ($past(i_rx_code_err) | $past(i_rx_disp_viol))
			&& o_disp_err == $past(i_rx_disp_viol);
	endproperty
	a_pair: assert property (p_pair) else $error("error pair wrong");
	property p_rdisp;
		dv |=> o_running_disp == $past(i_rx_rd_neg);
	endproperty
	a_rdisp: assert property (p_rdisp) else $error("disparity wrong");
	property p_off;
		!i_dec_enable |=> o_ctrl_detect == 0 && o_err_detect == 0
			&& o_disp_err == 0 && o_running_disp == 0;
	endproperty
	a_off: assert property (p_off) else $error("indicators not low");
	property p_order;
		$rose(o_order_status) |-> $past(i_rx_valid)
			&& $past(i_rx_byte[BYTE_W-1:0]) == ORDER_PATTERN;
	endproperty
	a_order: assert property (p_order) else $error("status without match");
	property p_mode;
		$past(i_reset_n, 3) |-> o_loop_mode_sel == ($past(i_lock_to_data, 3)
			? 2'h2 : {1'h0, $past(i_lock_to_ref, 3)});
	endproperty
	a_mode: assert property (p_mode) else $error("lock mode wrong");
	c_full: cover property ($rose(o_rm_full));
	c_order: cover property ($rose(o_order_status));
	c_disp: cover property (dv && i_rx_disp_viol != 0);
endmodule
bind srpcs_top srpcs_top_props #(.BYTE_W(BYTE_W), .BYTES_PER_CH(BYTES_PER_CH),
	.NUM_CH(NUM_CH), .ORDER_PATTERN(ORDER_PATTERN)) u_props (.*);

// ### srpcs_fabric_model.sv
// Fabric-side reader of the receive phase-compensation FIFO
`timescale 1ns/1ps
module srpcs_fabric_model
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_stall,
	input wire logic i_slow,
	output logic o_rd_ready
);
	logic half_reg;
	// Read strobe runs on the core clock itself
	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			half_reg <= 1'h0;
			o_rd_ready <= 1'h0;
		end
		else
		begin
			half_reg <= !half_reg;
			o_rd_ready <= !i_stall && (!i_slow || half_reg);
		end
	end
endmodule

// ### srpcs_top_test.sv
// Self-checking bench for the receiver status and control block
`timescale 1ns/1ps
module srpcs_top_test;
	logic i_ref_clk = 1'h0, i_reset_n = 1'h0, i_byte_ser_present = 1'h0;
	logic i_rm_fifo_used = 1'h0, i_dec_enable = 1'h0, i_order_enable = 1'h0;
	logic i_pcie_mode = 1'h0, i_basic_mode = 1'h0, i_idle_infer_en = 1'h0;
	logic i_rm_full_raw = 1'h0, i_rm_empty_raw = 1'h0, i_rx_valid = 1'h0;
	logic i_order_restart = 1'h0, i_lock_to_data = 1'h0, i_lock_to_ref = 1'h0;
	logic i_loop_locked_ref = 1'h0, i_loop_on_data = 1'h0, stall = 1'h0;
	logic i_loopback_sel = 1'h0, i_amp_above_thr = 1'h0, slow = 1'h0;
	logic [15:0] i_rx_byte = 16'h0;
	logic [1:0] i_rx_is_ctrl = 2'h0, i_rx_code_err = 2'h0;
	logic [1:0] i_rx_disp_viol = 2'h0, i_rx_rd_neg = 2'h0;
	logic i_rd_ready, o_rm_full, o_rm_empty, o_order_status, o_rx_data_valid;
	logic o_rec_clk_en, o_pc_fifo_error, o_loop_ref_locked, o_loop_data_mode;
	logic o_signal_detect, o_pipe_elec_idle, o_serial_loopback;
	logic [1:0] o_ctrl_detect, o_err_detect, o_disp_err, o_running_disp;
	logic [1:0] o_loop_mode_sel;
	logic [15:0] o_rx_data;
	logic [7:0] dec_out, ex;
	logic [31:0] r;
	logic [15:0] q[$];
	int seed = 32'h786e13b6;
	int fail_count = 0;
	int checks = 0;
	int n;
	assign dec_out = {o_ctrl_detect, o_err_detect, o_disp_err, o_running_disp};
	srpcs_top dut (.*);
	srpcs_fabric_model fab (.i_ref_clk, .i_reset_n, .i_stall(stall),
		.i_slow(slow), .o_rd_ready(i_rd_ready));
	initial
	begin
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	task cyc(input int c);
		repeat (c) @(negedge i_ref_clk);
	endtask
	task chk(input logic [15:0] g, e);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function logic [7:0] dec_exp(input logic [1:0] c, e, d, g);
		return {c, e | d, d, g};
	endfunction
	function logic [1:0] mode_exp(input logic d, f);
		return d ? 2'h2 : {1'h0, f};
	endfunction
	task rm(input logic ser, full);
		i_byte_ser_present = ser;
		cyc(1);
		i_rm_full_raw = full;
		i_rm_empty_raw = !full;
		cyc(1);
		i_rm_full_raw = 1'h0;
		i_rm_empty_raw = 1'h0;
		n = 0;
		repeat (8)
		begin
			if ((full ? o_rm_full : o_rm_empty) === 1'h1)
				n++;
			cyc(1);
		end
		chk(n[15:0], ser ? 16'h3 : 16'h2);
	endtask
	task word(input logic [15:0] w);
		i_rx_valid = 1'h1;
		i_rx_byte = w;
		cyc(1);
		i_rx_valid = 1'h0;
		cyc(2);
	endtask
	initial
	begin
		#200000;
		fail_count++;
		end_sim();
	end
	initial
	begin
		cyc(10);
		chk(o_pc_fifo_error, 1'h1);
		cyc(2);
		i_reset_n = 1'h1;
		cyc(2);
		for (int k = 0; k < 4; k++)
			rm(k[0], k[1]);
		i_dec_enable = 1'h1;
		for (int i = 0; i < 32; i++)
		begin
			cyc(1);
			if (i > 0)
				chk(dec_out, ex);
			r = $random(seed);
			{i_rx_is_ctrl, i_rx_code_err, i_rx_disp_viol, i_rx_rd_neg} = r[7:0];
			if (i == 1)
				{i_rx_code_err, i_rx_disp_viol} = 4'hd;
			i_rx_byte = r[23:8];
			i_rx_valid = i < 30;
			// Without a valid word the indicators keep their last values
			if (i < 30)
				ex = dec_exp(i_rx_is_ctrl, i_rx_code_err, i_rx_disp_viol,
					i_rx_rd_neg);
		end
		i_dec_enable = 1'h0;
		i_rx_valid = 1'h1;
		cyc(2);
		chk(dec_out, 8'h0);
		i_rx_valid = 1'h0;
		for (int k = 0; k < 8; k++)
		begin
			{i_lock_to_data, i_lock_to_ref, i_loopback_sel} = k[2:0];
			{i_loop_on_data, i_loop_locked_ref} = k[1:0];
			cyc(4);
			chk(o_loop_mode_sel, mode_exp(k[2], k[1]));
			chk(o_serial_loopback, k[0]);
			chk(o_loop_ref_locked, k[0]);
			chk(o_loop_data_mode, k[1]);
		end
		i_dec_enable = 1'h1;
		for (int k = 0; k < 32; k++)
		begin
			{i_rm_fifo_used, i_pcie_mode, i_basic_mode, i_idle_infer_en,
				i_amp_above_thr} = k[4:0];
			cyc(4);
			chk(o_signal_detect, k[0] & (k[3] | k[2]));
			chk(o_pipe_elec_idle, k[3] & !k[1] & !k[0]);
			chk(o_rec_clk_en, !k[4]);
		end
		i_order_enable = 1'h1;
		cyc(3);
		word(16'h00bc);
		chk(o_order_status, 1'h1);
		i_order_restart = 1'h1;
		cyc(6);
		chk(o_order_status, 1'h0);
		word(16'hbc00);
		chk(o_order_status, 1'h0);
		word(16'h11bc);
		chk(o_order_status, 1'h1);
		i_order_restart = 1'h0;
		cyc(4);
		i_order_restart = 1'h1;
		cyc(6);
		chk(o_order_status, 1'h0);
		stall = 1'h1;
		cyc(3);
		chk(o_pc_fifo_error, 1'h1);
		for (int k = 0; k < 10; k++)
		begin
			r = $random(seed);
			i_rx_byte = r[15:0];
			i_rx_valid = 1'h1;
			if (k < 8)
				q.push_back(r[15:0]);
			if (k == 3)
				chk(o_pc_fifo_error, 1'h0);
			cyc(1);
		end
		i_rx_valid = 1'h0;
		cyc(2);
		chk(o_pc_fifo_error, 1'h1);
		stall = 1'h0;
		slow = 1'h1;
		n = 0;
		repeat (40)
		begin
			cyc(1);
			if (o_rx_data_valid === 1'h1)
			begin
				chk(o_rx_data, q[n]);
				n++;
			end
		end
		chk(n[15:0], 16'h8);
		chk(o_pc_fifo_error, 1'h1);
		end_sim();
	end
endmodule
